// ==== verilog/dbtc_pkg.sv ====
// dual byte timer/counter package: register map, fields, reset values
// assumes: apb slave with 32-bit data, one word per register index
package dbtc_pkg;

    // ------------------------------------------------------------
    // bus widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 20;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BYTE_W = 8;

    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_CONTROL       = 16'hFE10;
    localparam logic [15:0] IDX_PRESCALE      = 16'hFE11;
    localparam logic [15:0] IDX_COUNT_LOW     = 16'hFE12;
    localparam logic [15:0] IDX_COUNT_HIGH    = 16'hFE13;
    localparam logic [15:0] IDX_MATCH_LOW     = 16'hFE14;
    localparam logic [15:0] IDX_MATCH_HIGH    = 16'hFE15;
    localparam logic [15:0] IDX_CAPTURE_LOW   = 16'hFE16;
    localparam logic [15:0] IDX_CAPTURE_HIGH  = 16'hFE17;
    localparam int unsigned IDX_SHIFT         = 2;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int unsigned BIT_HIGH_RUN   = 7;
    localparam int unsigned BIT_LOW_RUN    = 6;
    localparam int unsigned BIT_LEN16      = 5;
    localparam int unsigned BIT_LOW_EXT    = 4;
    localparam int unsigned BIT_HIGH_FLAG  = 3;
    localparam int unsigned BIT_HIGH_IE    = 2;
    localparam int unsigned BIT_LOW_FLAG   = 1;
    localparam int unsigned BIT_LOW_IE     = 0;

    // ------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [7:0] BYTE_ONE   = 8'h01;
    localparam logic [7:0] BYTE_FULL  = 8'hFF;
    localparam logic [15:0] WORD_ONE  = 16'h0001;

    // byte-wide register value
    typedef logic [7:0] dbtc_byte_t;

endpackage

// ==== verilog/dbtc_top.sv ====
// dual byte timer/counter with prescaler, match buffers and capture
// assumes: apb master on sys_clk, trigger inputs synchronous to sys_clk
// assumes: hold_mode is high only while the surrounding device halts
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none

module dbtc_top (
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [dbtc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [dbtc_pkg::DATA_W-1:0] pwdata,
    output logic      [dbtc_pkg::DATA_W-1:0] prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     hold_mode,
    input  wire logic                     ext_count_in,
    input  wire logic                     capture_low_in,
    input  wire logic                     capture_high_in,
    output logic                          irq_low,
    output logic                          irq_high
);
    import dbtc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic              ready;
        logic              slverr;
        dbtc_byte_t        ctrl;
        dbtc_byte_t        prr;
        dbtc_byte_t        pre_cnt;
        dbtc_byte_t        cnt_l;
        dbtc_byte_t        cnt_h;
        dbtc_byte_t        mreg_l;
        dbtc_byte_t        mreg_h;
        dbtc_byte_t        mbuf_l;
        dbtc_byte_t        mbuf_h;
        dbtc_byte_t        cap_l;
        dbtc_byte_t        cap_h;
        logic [2:0]        sync_a;
        logic [2:0]        sync_b;
        logic [2:0]        sync_d;
        logic              irq_l;
        logic              irq_h;
    } dbtc_state_s;

    dbtc_state_s st_ff;
    dbtc_state_s nxt_st;

    // ------------------------------------------------------------
    // decode and combinational helpers
    // ------------------------------------------------------------
    logic [15:0] idx;
    logic        addr_ok;
    logic        acc_new;
    logic        wr_take;
    logic [7:0]  wbyte;
    logic        run_h;
    logic        run_l;
    logic        len16;
    logic        pre_tick;
    logic [2:0]  pulse;
    logic        tick_l;
    logic        tick_h;
    logic        match_l;
    logic        match_h;
    logic        match16;
    logic [15:0] cnt16;
    logic [15:0] cnt16_inc;
    logic [7:0]  rd_byte;
    logic        cap_trig_l;
    logic        set_l;
    logic        set_h;

    // a byte address is four times the word index, so the low two
    // address bits must be zero; other values are refused with an
    // error instead of aliasing onto a register
    // ready in the state keeps a held access from being answered twice
    // word index from byte address, lower two bits ignored
    assign idx     = 16'(paddr >> IDX_SHIFT);
    assign acc_new = psel & penable & ~st_ff.ready;
    assign wr_take = psel & penable & st_ff.ready & pwrite & addr_ok;
    assign wbyte   = pwdata[7:0];

    // control fields
    assign run_h = st_ff.ctrl[BIT_HIGH_RUN];
    assign run_l = st_ff.ctrl[BIT_LOW_RUN];
    assign len16 = st_ff.ctrl[BIT_LEN16];

    // the prescaler counts 0 up to the setting and pulses on the last
    // value, so one pulse every setting plus one cycles; a setting of
    // zero gives a pulse on every cycle
    // prescaler pulse, frozen in hold mode
    assign pre_tick = ~hold_mode & (st_ff.pre_cnt == st_ff.prr);

    // bit 0 external count, bit 1 low capture, bit 2 high capture;
    // the first stage is read by nothing but the second, and every
    // stage resets low like the idle pins, so no false edge is seen
    // when reset ends
    // edge pulses from the second and third synchroniser stages
    assign pulse = st_ff.sync_b & ~st_ff.sync_d;

    // an external count needs no prescaler at all
    // low byte clock source
    assign tick_l = st_ff.ctrl[BIT_LOW_EXT] ? pulse[0] : pre_tick;

    // in 16-bit use the high byte takes the low byte's carry instead
    // high byte clock: prescaler in 8-bit mode only
    assign tick_h = ~len16 & pre_tick;

    // a match is only looked at on a count tick, so a counter sitting
    // on its buffer value between ticks does not keep matching; when
    // chained, both bytes share the one 16-bit compare and the low
    // byte's tick drives both
    // match compare against buffers
    assign cnt16     = {st_ff.cnt_h, st_ff.cnt_l};
    assign cnt16_inc = cnt16 + WORD_ONE;
    assign match16 = (cnt16 == {st_ff.mbuf_h, st_ff.mbuf_l});
    assign match_l = len16 ? (tick_l & match16)
                           : (tick_l & st_ff.cnt_l == st_ff.mbuf_l);
    assign match_h = len16 ? (tick_l & match16)
                           : (tick_h & st_ff.cnt_h == st_ff.mbuf_h);

    // a match on a stopped byte cannot set its flag; the counter is
    // held at zero then anyway
    // flag set conditions; both in the same cycle when chained and both bytes run
    assign set_l = match_l & run_l;
    assign set_h = match_h & run_h;

    // in 16-bit use both captures follow the high trigger, so the two
    // bytes always hold one consistent 16-bit sample
    // capture trigger for the low byte follows the length bit
    assign cap_trig_l = len16 ? pulse[2] : pulse[1];

    // ------------------------------------------------------------
    // read mux and address check
    // ------------------------------------------------------------
    // read data is chosen from the word index; unmapped indices and
    // misaligned addresses read as zero and flag an error; count and
    // capture registers simply ignore writes
    always_comb begin
        addr_ok = 1'b1;
        rd_byte = RST_BYTE;
        unique case (idx)
            IDX_CONTROL:      rd_byte = st_ff.ctrl;
            IDX_PRESCALE:     rd_byte = st_ff.prr;
            IDX_COUNT_LOW:    rd_byte = st_ff.cnt_l;
            IDX_COUNT_HIGH:   rd_byte = st_ff.cnt_h;
            IDX_MATCH_LOW:    rd_byte = st_ff.mreg_l;
            IDX_MATCH_HIGH:   rd_byte = st_ff.mreg_h;
            IDX_CAPTURE_LOW:  rd_byte = st_ff.cap_l;
            IDX_CAPTURE_HIGH: rd_byte = st_ff.cap_h;
            default:          addr_ok = 1'b0;
        endcase
        if (paddr[IDX_SHIFT-1:0] != 2'b00) begin
            addr_ok = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;

        // the access is answered one cycle after it is first seen, so
        // read data always comes from a register and never straight
        // from the address decode
        // apb: one wait state, answer registered
        nxt_st.ready  = acc_new;
        nxt_st.slverr = acc_new & ~addr_ok;
        if (acc_new) begin
            nxt_st.rdata = addr_ok ? {24'h000000, rd_byte} : 32'h00000000;
        end

        // three stages per input: two to settle, one to find the
        // rising edge
        // synchroniser chain: ext count, low capture, high capture
        nxt_st.sync_a = {capture_high_in, capture_low_in, ext_count_in};
        nxt_st.sync_b = st_ff.sync_a;
        nxt_st.sync_d = st_ff.sync_b;

        // a write of the setting restarts the count and takes priority
        // over a pulse in the same cycle; hold mode freezes the count
        // where it stands
        // prescaler counter
        if (wr_take && idx == IDX_PRESCALE) begin
            nxt_st.prr     = wbyte;
            nxt_st.pre_cnt = RST_BYTE;
        end else if (hold_mode) begin
            nxt_st.pre_cnt = st_ff.pre_cnt;
        end else if (pre_tick) begin
            nxt_st.pre_cnt = RST_BYTE;
        end else begin
            nxt_st.pre_cnt = st_ff.pre_cnt + BYTE_ONE;
        end

        // match registers hold the next value until a buffer loads it
        // match registers, software writes
        if (wr_take && idx == IDX_MATCH_LOW) begin
            nxt_st.mreg_l = wbyte;
        end
        if (wr_take && idx == IDX_MATCH_HIGH) begin
            nxt_st.mreg_h = wbyte;
        end

        // the buffers let software load the next match value while a
        // byte runs without disturbing the period in progress; the new
        // value takes effect at the next match; the high buffer below
        // works the same way
        // low match buffer
        if (!run_l) begin
            nxt_st.mbuf_l = st_ff.mreg_l;
        end else if (match_l) begin
            nxt_st.mbuf_l = st_ff.mreg_l;
        end

        // high match buffer
        if (!run_h) begin
            nxt_st.mbuf_h = st_ff.mreg_h;
        end else if (match_h) begin
            nxt_st.mbuf_h = st_ff.mreg_h;
        end

        // stop wins over match, match over increment, so a stopped
        // byte always reads zero
        // low counter; counts are read-only to software
        if (!run_l) begin
            nxt_st.cnt_l = RST_BYTE;
        end else if (match_l) begin
            nxt_st.cnt_l = RST_BYTE;
        end else if (tick_l) begin
            nxt_st.cnt_l = st_ff.cnt_l + BYTE_ONE;
        end

        // when chained, the high byte moves only on the low byte's
        // wrap from all ones; a 16-bit match clears both bytes in the
        // same cycle through the shared compare
        // high counter: own tick, or carry of the low byte when chained
        if (!run_h) begin
            nxt_st.cnt_h = RST_BYTE;
        end else if (match_h) begin
            nxt_st.cnt_h = RST_BYTE;
        end else if (len16) begin
            // run bits may differ in 16-bit use, so carry only when low runs
            if (tick_l && run_l && st_ff.cnt_l == BYTE_FULL) begin
                nxt_st.cnt_h = cnt16_inc[15:8];
            end
        end else if (tick_h) begin
            nxt_st.cnt_h = st_ff.cnt_h + BYTE_ONE;
        end

        // the capture takes the count as it stands before this cycle's
        // increment; the stored value is zero after reset
        // capture registers take the current count
        if (cap_trig_l) begin
            nxt_st.cap_l = st_ff.cnt_l;
        end
        if (pulse[2]) begin
            nxt_st.cap_h = st_ff.cnt_h;
        end

        // all eight control bits are written as given, so writing zero
        // clears a flag; a hardware set in the same cycle wins, so a
        // match that lands on the clear is never lost and its request
        // stays raised
        // control: software write, flags set by hardware win the cycle
        if (wr_take && idx == IDX_CONTROL) begin
            nxt_st.ctrl = wbyte;
        end
        if (set_h) begin
            nxt_st.ctrl[BIT_HIGH_FLAG] = 1'b1;
        end
        if (set_l) begin
            nxt_st.ctrl[BIT_LOW_FLAG] = 1'b1;
        end

        // taken from the next control value so each request rises and
        // falls on the same edge as its flag or enable
        // interrupt requests from next control value
        nxt_st.irq_h = nxt_st.ctrl[BIT_HIGH_IE]
                     & nxt_st.ctrl[BIT_HIGH_FLAG];
        nxt_st.irq_l = nxt_st.ctrl[BIT_LOW_IE]
                     & nxt_st.ctrl[BIT_LOW_FLAG];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // one synchronous reset clears every field, the captures too,
    // whose value after reset is otherwise not promised
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from flip-flops
    // ------------------------------------------------------------
    // every output is a field of the state register, so no output
    // ever carries a combinational glitch
    assign prdata   = st_ff.rdata;
    assign pready   = st_ff.ready;
    assign pslverr  = st_ff.slverr;
    assign irq_low  = st_ff.irq_l;
    assign irq_high = st_ff.irq_h;

endmodule

`default_nettype wire

// ==== dv/dbtc_checker_assertions.sv ====
// bus and interrupt checks on the timer block's ports
// assumes: bound onto dbtc_top, one clock, synchronous reset
`timescale 1ns/100ps
`default_nettype none

module dbtc_checker (
    input wire logic                        sys_clk,
    input wire logic                        rst,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [dbtc_pkg::ADDR_W-1:0] paddr,
    input wire logic [dbtc_pkg::DATA_W-1:0] pwdata,
    input wire logic [dbtc_pkg::DATA_W-1:0] prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic                        hold_mode,
    input wire logic                        ext_count_in,
    input wire logic                        capture_low_in,
    input wire logic                        capture_high_in,
    input wire logic                        irq_low,
    input wire logic                        irq_high
);
    import dbtc_pkg::*;
    localparam logic [ADDR_W-1:0] CTL_A = ADDR_W'(IDX_CONTROL) << IDX_SHIFT;
    localparam logic [ADDR_W-1:0] CNT_A = ADDR_W'(IDX_COUNT_LOW) << IDX_SHIFT;
    wire logic ctl_wr;

    // --------------------------------------------------------
    // bus timing and interrupt hold
    // --------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // completed write to the control register
    assign ctl_wr = psel && penable && pready && pwrite && paddr == CTL_A;
    one_wait_a: assert property (psel && penable && $past(psel && !penable)
        |=> pready) else $error("answer not after one wait");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    err_data_a: assert property (pslverr |-> prdata == 32'h00000000)
        else $error("error with data");
    misalign_err_a: assert property (pready && paddr[1:0] != 2'b00
        |-> pslverr) else $error("misaligned not refused");
    count_ok_a: assert property (
        pready && paddr == CNT_A |-> !pslverr)
        else $error("count read refused");
    low_irq_hold_a: assert property (
        $fell(irq_low) |-> $past(ctl_wr) || $past(ctl_wr, 2)
        || $past(ctl_wr, 3)) else $error("low irq fell");
    high_irq_hold_a: assert property (
        $fell(irq_high) |-> $past(ctl_wr) || $past(ctl_wr, 2)
        || $past(ctl_wr, 3)) else $error("high irq fell");
endmodule

bind dbtc_top dbtc_checker dbtc_checker_inst (.sys_clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .hold_mode, .ext_count_in, .capture_low_in, .capture_high_in,
    .irq_low, .irq_high);
`default_nettype wire

// ==== dv/dbtc_trig_model.sv ====
// model of the external count and capture trigger sources
// assumes: lines driven just after rising edges of sys_clk
`timescale 1ns/100ps
`default_nettype none

module dbtc_trig_model (
    input  wire logic sys_clk,
    output logic      ext_count_in,
    output logic      capture_low_in,
    output logic      capture_high_in
);
    // --------------------------------------------------------
    // idle low, then rising edges on request
    // --------------------------------------------------------
    initial begin
        ext_count_in = 1'b0;
        capture_low_in = 1'b0;
        capture_high_in = 1'b0;
    end
    // n edges: two cycles high, two low, so the sync sees each one
    task automatic pulse(input int sel, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            case (sel)
                0: ext_count_in <= 1'b1;
                1: capture_low_in <= 1'b1;
                default: capture_high_in <= 1'b1;
            endcase
            repeat (2) @(posedge sys_clk);
            ext_count_in <= 1'b0;
            capture_low_in <= 1'b0;
            capture_high_in <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
endmodule
`default_nettype wire

// ==== dv/dbtc_top_tb.sv ====
// self-checking bench for the timer block over apb
// assumes: dbtc_pkg compiled first, checker bound separately
`timescale 1ns/100ps
`default_nettype none

module dbtc_top_tb;
    import dbtc_pkg::*;
    logic              sys_clk, rst, psel, penable, pwrite, hold_mode;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rdv;
    logic              pready, pslverr, irq_low, irq_high, erv;
    wire logic         ext_count_in, capture_low_in, capture_high_in;
    int                n_fail = 0;
    int                tests_run = 0;
    int                cyc = 0;
    int                t1;

    dbtc_top dbtc_top_inst (.sys_clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .hold_mode,
        .ext_count_in, .capture_low_in, .capture_high_in, .irq_low,
        .irq_high);
    dbtc_trig_model dbtc_trig_model_inst (.sys_clk, .ext_count_in,
        .capture_low_in, .capture_high_in);

    // --------------------------------------------------------
    // clock, cycle count and hang guard
    // --------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            $display("[ERR] %0t timeout", $time);
            n_fail++;
            stop_test();
        end
    end

    // --------------------------------------------------------
    // tasks
    // --------------------------------------------------------
    task automatic stop_test();
        if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h want %h", $time, got, exp);
            n_fail++;
        end
    endtask
    function automatic logic [ADDR_W-1:0] ba(input logic [15:0] idx);
        return ADDR_W'(idx) << IDX_SHIFT;
    endfunction
    // one transfer: setup, access held until ready
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [7:0] wd, output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        // wait as long as the slave needs; the hang guard ends a stall
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        apb(1'b1, ba(idx), d, rdv, erv);
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
        apb(1'b0, ba(idx), 8'h00, rdv, erv);
        chk(rdv, {24'h000000, exp});
    endtask
    task automatic wait_lvl(input logic hi, input logic v);
        do begin
            @(posedge sys_clk);
        end while ((hi ? irq_high : irq_low) !== v);
    endtask
    // cycles between two requests, flag cleared in between
    task automatic period(input logic hi, input logic [7:0] ctl,
        input int exp);
        int tp;
        wait_lvl(hi, 1'b1);
        tp = cyc;
        wr(IDX_CONTROL, ctl);
        wait_lvl(hi, 1'b0);
        wait_lvl(hi, 1'b1);
        chk(32'(cyc - tp), 32'(exp));
    endtask

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        hold_mode = 1'b0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        // reset values, refused places, read-only count
        for (int i = 0; i < 6; i++) rdc(IDX_CONTROL + 16'(i), 8'h00);
        apb(1'b0, ba(16'hFE18), 8'h00, rdv, erv);
        chk({31'h0, erv}, 32'h1);
        apb(1'b1, ba(IDX_CONTROL) + 20'h1, 8'hFF, rdv, erv);
        chk({31'h0, erv}, 32'h1);
        rdc(IDX_CONTROL, 8'h00);
        wr(IDX_COUNT_LOW, 8'h55);
        rdc(IDX_COUNT_LOW, 8'h00);
        // low byte on prescaler, 3 ticks of 4 cycles
        wr(IDX_PRESCALE, 8'h03);
        wr(IDX_MATCH_LOW, 8'h02);
        wr(IDX_CONTROL, 8'h41);
        period(1'b0, 8'h41, 12);
        wr(IDX_CONTROL, 8'h00);
        rdc(IDX_COUNT_LOW, 8'h00);
        // high byte alone, 10 ticks of 1 cycle
        wr(IDX_PRESCALE, 8'h00);
        wr(IDX_MATCH_HIGH, 8'h09);
        wr(IDX_CONTROL, 8'h84);
        period(1'b1, 8'h84, 10);
        chk({31'h0, irq_low}, 32'h0);
        // sixteen-bit match at 0x0102, both flags at once
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_MATCH_LOW, 8'h02);
        wr(IDX_MATCH_HIGH, 8'h01);
        wr(IDX_CONTROL, 8'hE5);
        t1 = cyc;
        wait_lvl(1'b0, 1'b1);
        chk({31'h0, irq_high}, 32'h1);
        // 0x103 ticks of one cycle, request seen one edge later
        chk(32'(cyc - t1), 32'h00000104);
        // external events on the low byte, then capture
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_MATCH_LOW, 8'hFF);
        wr(IDX_CONTROL, 8'h50);
        dbtc_trig_model_inst.pulse(0, 5);
        repeat (4) @(posedge sys_clk);
        rdc(IDX_COUNT_LOW, 8'h05);
        dbtc_trig_model_inst.pulse(1, 1);
        repeat (4) @(posedge sys_clk);
        rdc(IDX_CAPTURE_LOW, 8'h05);
        // chained external count: carry into the high byte, then both
        // captures on the high trigger only
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_CONTROL, 8'hF0);
        dbtc_trig_model_inst.pulse(0, 258);
        rdc(IDX_COUNT_HIGH, 8'h01);
        rdc(IDX_COUNT_LOW, 8'h02);
        dbtc_trig_model_inst.pulse(1, 1);
        rdc(IDX_CAPTURE_LOW, 8'h05);
        dbtc_trig_model_inst.pulse(2, 1);
        rdc(IDX_CAPTURE_LOW, 8'h02);
        rdc(IDX_CAPTURE_HIGH, 8'h01);
        // setting rewrites every four cycles keep a setting of 8 from
        // ever pulsing, so the low byte never moves
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_PRESCALE, 8'h08);
        wr(IDX_CONTROL, 8'h40);
        for (int i = 0; i < 5; i++) wr(IDX_PRESCALE, 8'h08);
        rdc(IDX_COUNT_LOW, 8'h00);
        // hold mode stops prescaler ticks
        wr(IDX_CONTROL, 8'h00);
        hold_mode <= 1'b1;
        wr(IDX_CONTROL, 8'h40);
        repeat (20) @(posedge sys_clk);
        rdc(IDX_COUNT_LOW, 8'h00);
        stop_test();
    end
endmodule
`default_nettype wire
